// File: comc_mode_ctrl.sv
// processor operating mode controller: protection, paging and long mode state
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module comc_mode_ctrl
    import comc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [DATA_W-1:0] regRdData,
    // far branch from the core
    input wire logic farBranch,
    input wire logic [SEL_W-1:0] farBranchSel,
    input wire logic [DATA_W-1:0] farBranchBase,
    input wire logic farBranchLong,
    // segment loads from the core
    input wire logic segLoad,
    input wire logic [SEG_IDX_W-1:0] segLoadIdx,
    input wire logic [SEL_W-1:0] segLoadSel,
    input wire logic [ATTR_W-1:0] segLoadAttr,
    // upper register file activity
    input wire logic upperRegWrite,
    // mode state
    output logic [1:0] cpuMode,
    output logic [PRIV_W-1:0] curPriv,
    output logic protOn,
    output logic pagingOn,
    output logic longModeActive,
    output logic upperRegsValid,
    output logic serializePulse,
    output logic flushQueue,
    output logic [DATA_W-1:0] csBase
);

    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    logic protEn_q, protEn_d;
    logic pageEn_q, pageEn_d;
    logic lmEnable_q, lmEnable_d;
    logic lmActive_q, lmActive_d;
    logic csLong_q, csLong_d;
    logic awaitBranch_q, awaitBranch_d;
    logic upperValid_q, upperValid_d;
    logic [PRIV_W-1:0] curPriv_q, curPriv_d;
    logic [DATA_W-1:0] pageBase_q, gtBase_q, itBase_q;
    logic [SEL_W-1:0] ltSel_q, tsSel_q;
    logic [DATA_W-1:0] csBase_q, csBase_d;
    logic serialize_q, flush_q;
    logic [DATA_W-1:0] rdData_q;
    comc_mode_t mode_q, mode_d;

    comc_seg_if segIf ();

    comc_seg_bank #(
        .NUM_SEG(SEG_CNT)
    ) comc_seg_bank_inst (
        .clk(clk),
        .rst_b(rst_b),
        .segIf(segIf.bank)
    );

    //--------------------------------------------------------------------------
    // address decode
    //--------------------------------------------------------------------------
    function automatic logic hitReg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hitReg = (a == off);
    endfunction

    wire wrMctl = regWrEn && hitReg(regAddr, OFF_MCTL);
    wire wrEfr = regWrEn && hitReg(regAddr, OFF_EFR);
    wire wrPgBase = regWrEn && hitReg(regAddr, OFF_PGBASE);
    wire wrGtBase = regWrEn && hitReg(regAddr, OFF_GTBASE);
    wire wrItBase = regWrEn && hitReg(regAddr, OFF_ITBASE);
    wire wrLtSel = regWrEn && hitReg(regAddr, OFF_LTSEL);
    wire wrTsSel = regWrEn && hitReg(regAddr, OFF_TSSEL);
    wire [ADDR_W-1:0] segOff = regAddr - OFF_SEG0;
    wire segHit = (regAddr >= OFF_SEG0) && (segOff[1:0] == 2'h0)
        && (segOff[ADDR_W-1:2] < (ADDR_W-2)'(SEG_CNT));

    //--------------------------------------------------------------------------
    // control register write: protection, paging, long mode
    //--------------------------------------------------------------------------
    wire newProt = regWrData[BIT_PROT];
    // paging cannot run without protection, so the paging bit of a paging-only write is dropped
    wire newPage = regWrData[BIT_PAGE] && newProt;
    wire pageChange = wrMctl && (newPage != pageEn_q);
    wire protChange = wrMctl && (newProt != protEn_q);
    wire enterProt = wrMctl && newProt && !protEn_q;
    wire newLmEn = regWrData[BIT_LMEN];

    assign protEn_d = wrMctl ? newProt : protEn_q;
    assign pageEn_d = wrMctl ? newPage : pageEn_q;
    assign lmEnable_d = wrEfr ? newLmEn : lmEnable_q;

    always_comb begin
        lmActive_d = lmActive_q;
        if (pageChange) begin
            lmActive_d = newPage && newProt && lmEnable_q;
        end else if (wrMctl) begin
            lmActive_d = lmActive_q && newProt;
        end else if (wrEfr) begin
            lmActive_d = lmActive_q && newLmEn;
        end
    end

    // set wins: a branch taken in the same cycle belongs to the earlier switch
    assign awaitBranch_d = protChange || (awaitBranch_q && !farBranch);

    //--------------------------------------------------------------------------
    // far branch: code segment reload, privilege, serialization
    //--------------------------------------------------------------------------
    wire realBranch = farBranch && !protEn_q;
    wire [DATA_W-1:0] realBase = DATA_W'({farBranchSel, REAL_SHIFT_PAD});

    assign csBase_d = farBranch ? (protEn_q ? farBranchBase : realBase) : csBase_q;
    assign csLong_d = farBranch ? (farBranchLong && protEn_q) : csLong_q;

    always_comb begin
        curPriv_d = curPriv_q;
        if (enterProt || !protEn_d) begin
            curPriv_d = PRIV_ZERO;
        end else if (farBranch && protEn_q) begin
            curPriv_d = farBranchSel[PRIV_W-1:0];
        end
    end

    // compatibility mode keeps upper registers; leaving long mode loses them
    wire lmFall = lmActive_q && !lmActive_d;
    assign upperValid_d = lmFall ? 1'b0 : (upperValid_q || upperRegWrite);

    always_comb begin
        mode_d = MODE_REAL;
        if (protEn_d && lmActive_d) begin
            mode_d = csLong_d ? MODE_LONG64 : MODE_COMPAT;
        end else if (protEn_d) begin
            mode_d = MODE_PROT;
        end
    end

    //--------------------------------------------------------------------------
    // segment bank hookup
    //--------------------------------------------------------------------------
    assign segIf.loadEn = segLoad;
    assign segIf.loadIdx = segLoadIdx;
    assign segIf.loadSel = segLoadSel;
    assign segIf.loadAttr = segLoadAttr;
    assign segIf.realMode = !protEn_q;
    assign segIf.rdIdx = segOff[SEG_IDX_W+1:2];

    //--------------------------------------------------------------------------
    // read mux
    //--------------------------------------------------------------------------
    logic [DATA_W-1:0] rdMux;
    always_comb begin
        rdMux = WORD_RST;
        if (segHit) begin
            rdMux[SEL_W-1:0] = segIf.rdSel;
            rdMux[SEG_ATTR_LSB +: ATTR_W] = segIf.rdAttr;
            rdMux[SEG_USABLE] = segIf.rdUsable;
        end else begin
            unique case (regAddr)
                OFF_MCTL: begin
                    rdMux[BIT_PROT] = protEn_q;
                    rdMux[BIT_PAGE] = pageEn_q;
                end
                OFF_EFR: begin
                    rdMux[BIT_LMEN] = lmEnable_q;
                    rdMux[BIT_LMACT] = lmActive_q;
                end
                OFF_PGBASE: rdMux = pageBase_q;
                OFF_GTBASE: rdMux = gtBase_q;
                OFF_ITBASE: rdMux = itBase_q;
                OFF_LTSEL: rdMux[SEL_W-1:0] = ltSel_q;
                OFF_TSSEL: rdMux[SEL_W-1:0] = tsSel_q;
                OFF_STATUS: begin
                    rdMux[ST_MODE_LSB +: 2] = mode_q;
                    rdMux[ST_PRIV_LSB +: PRIV_W] = curPriv_q;
                    rdMux[ST_AWAIT] = awaitBranch_q;
                    rdMux[ST_UPPER] = upperValid_q;
                    rdMux[ST_CSLONG] = csLong_q;
                end
                default: rdMux = WORD_RST;
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // flip-flops
    //--------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            protEn_q <= 1'b0;
            pageEn_q <= 1'b0;
            lmEnable_q <= 1'b0;
            lmActive_q <= 1'b0;
            csLong_q <= 1'b0;
            awaitBranch_q <= 1'b0;
            upperValid_q <= 1'b0;
            curPriv_q <= PRIV_ZERO;
            csBase_q <= WORD_RST;
            mode_q <= MODE_REAL;
        end else begin
            protEn_q <= protEn_d;
            pageEn_q <= pageEn_d;
            lmEnable_q <= lmEnable_d;
            lmActive_q <= lmActive_d;
            csLong_q <= csLong_d;
            awaitBranch_q <= awaitBranch_d;
            upperValid_q <= upperValid_d;
            curPriv_q <= curPriv_d;
            csBase_q <= csBase_d;
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serialize_q <= 1'b0;
            flush_q <= 1'b0;
            rdData_q <= WORD_RST;
        end else begin
            serialize_q <= farBranch && awaitBranch_q;
            flush_q <= realBranch && awaitBranch_q;
            rdData_q <= regRdEn ? rdMux : WORD_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pageBase_q <= WORD_RST;
            gtBase_q <= WORD_RST;
            itBase_q <= WORD_RST;
            ltSel_q <= SEL_RST;
            tsSel_q <= SEL_RST;
        end else begin
            if (wrPgBase) pageBase_q <= regWrData;
            if (wrGtBase) gtBase_q <= regWrData;
            if (wrItBase) itBase_q <= regWrData;
            if (wrLtSel) ltSel_q <= regWrData[SEL_W-1:0];
            if (wrTsSel) tsSel_q <= regWrData[SEL_W-1:0];
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign regRdData = rdData_q;
    assign cpuMode = mode_q;
    assign curPriv = curPriv_q;
    assign protOn = protEn_q;
    assign pagingOn = pageEn_q;
    assign longModeActive = lmActive_q;
    assign upperRegsValid = upperValid_q;
    assign serializePulse = serialize_q;
    assign flushQueue = flush_q;
    assign csBase = csBase_q;

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    AST_LM_DROP: assert property (@(posedge clk) disable iff (!rst_b)
        (wrMctl && !regWrData[BIT_PAGE] && lmActive_q) |=> !lmActive_q && cpuMode == MODE_PROT)
        else $error("long mode stayed active after paging was cleared");
    AST_LM_CONSIST: assert property (@(posedge clk) disable iff (!rst_b)
        lmActive_q |-> (lmEnable_q && pageEn_q && protEn_q))
        else $error("long mode active without all enables");
    AST_PROT_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
        (wrMctl && regWrData[BIT_PROT]) |=> protOn && pagingOn == $past(regWrData[BIT_PAGE]))
        else $error("protection write did not enter protected mode");
    AST_PRIV_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        (wrMctl && regWrData[BIT_PROT] && !protEn_q) |=> curPriv == 2'h0)
        else $error("protected mode entry not at privilege zero");
    AST_REAL_RETURN: assert property (@(posedge clk) disable iff (!rst_b)
        (wrMctl && !regWrData[BIT_PROT]) |=> !protOn && !pagingOn && cpuMode == MODE_REAL)
        else $error("clearing protection did not return to real mode");
    AST_SERIALIZE: assert property (@(posedge clk) disable iff (!rst_b)
        (awaitBranch_q && farBranch && !wrMctl) |=> serializePulse ##1 !serializePulse)
        else $error("branch after protection entry did not serialize once");
    AST_REAL_BRANCH: assert property (@(posedge clk) disable iff (!rst_b)
        (awaitBranch_q && farBranch && !protEn_q) |=> flushQueue && csBase == $past(realBase))
        else $error("real mode branch did not flush and load code base");
    AST_UPPER_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
        (upperValid_q && lmActive_q && lmActive_d) |=> upperRegsValid)
        else $error("upper registers lost while staying in long mode");
    AST_UPPER_LOST: assert property (@(posedge clk) disable iff (!rst_b)
        (lmActive_q && !lmActive_d) |=> !upperRegsValid)
        else $error("upper registers still valid after leaving long mode");

    COV_ENTER_PROT: cover property (@(posedge clk) disable iff (!rst_b)
        enterProt ##[1:4] farBranch ##1 serializePulse);
    COV_LEAVE_LONG: cover property (@(posedge clk) disable iff (!rst_b)
        (lmActive_q && pageChange) ##[1:20] (wrMctl && newPage && !lmActive_q));
    COV_COMPAT_RT: cover property (@(posedge clk) disable iff (!rst_b)
        (cpuMode == MODE_COMPAT) ##[1:20] (cpuMode == MODE_LONG64 && upperRegsValid));
    COV_REAL_RETURN: cover property (@(posedge clk) disable iff (!rst_b)
        (protChange && !newProt) ##[1:5] flushQueue);
endmodule
`default_nettype wire

// File: comc_pkg.sv
// constants, types and register map of the cpu operating mode control block
//------------------------------------------------------------------------------
// Contract
// - clearing paging while long mode is active clears the long mode active flag
// - upper registers survive 64-bit to compatibility mode and back
// - upper registers become undefined after passing through legacy or real mode
// - writing protection enable enters protected mode, paging may be set together
// - protected mode execution starts at privilege level zero
// - that far branch reloads code segment and serializes the core
// - data and stack segments keep real mode contents until reloaded
// - clearing protection enable returns the core to real-address mode
// - unreloaded segments keep protected attributes; null selectors unusable in real mode
// - far jump after clearing protection flushes queue and loads real code segment
//------------------------------------------------------------------------------
package comc_pkg;

    //--------------------------------------------------------------------------
    // register map, byte addresses on the register port
    //--------------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_MCTL = 8'h00;
    localparam logic [7:0] OFF_EFR = 8'h04;
    localparam logic [7:0] OFF_PGBASE = 8'h08;
    localparam logic [7:0] OFF_GTBASE = 8'h0C;
    localparam logic [7:0] OFF_ITBASE = 8'h10;
    localparam logic [7:0] OFF_LTSEL = 8'h14;
    localparam logic [7:0] OFF_TSSEL = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_SEG0 = 8'h20;
    localparam int SEG_CNT = 5;
    localparam int SEG_IDX_W = 3;

    //--------------------------------------------------------------------------
    // field positions
    //--------------------------------------------------------------------------
    localparam int BIT_PROT = 0;
    localparam int BIT_PAGE = 31;
    localparam int BIT_LMEN = 8;
    localparam int BIT_LMACT = 10;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_PRIV_LSB = 2;
    localparam int ST_AWAIT = 4;
    localparam int ST_UPPER = 5;
    localparam int ST_CSLONG = 6;
    localparam int SEG_ATTR_LSB = 16;
    localparam int SEG_USABLE = 24;

    //--------------------------------------------------------------------------
    // widths and reset values
    //--------------------------------------------------------------------------
    localparam int SEL_W = 16;
    localparam int ATTR_W = 8;
    localparam int PRIV_W = 2;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [1:0] PRIV_ZERO = 2'h0;
    localparam logic [7:0] ATTR_REAL = 8'h93;
    localparam logic [3:0] REAL_SHIFT_PAD = 4'h0;
    localparam logic [SEL_W-1:0] SEL_RST = 16'h0000;

    typedef enum logic [1:0] {
        MODE_REAL,
        MODE_PROT,
        MODE_COMPAT,
        MODE_LONG64
    } comc_mode_t;

endpackage

// File: comc_seg_bank.sv
// data and stack segment registers with their cached attributes
`timescale 1ns/100ps
`default_nettype none
module comc_seg_bank
    import comc_pkg::*;
#(
    parameter int NUM_SEG = SEG_CNT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // controller side
    comc_seg_if.bank segIf
);

    function automatic logic isNullSel(input logic [SEL_W-1:0] sel);
        isNullSel = (sel[SEL_W-1:PRIV_W] == '0);
    endfunction

    logic [SEL_W-1:0] sel_q [NUM_SEG];
    logic [ATTR_W-1:0] attr_q [NUM_SEG];
    logic unusable_q [NUM_SEG];

    //--------------------------------------------------------------------------
    // one register per segment
    //--------------------------------------------------------------------------
    for (genvar i = 0; i < NUM_SEG; i++) begin : gSeg
        wire hit = segIf.loadEn && (segIf.loadIdx == SEG_IDX_W'(i));
        // contents stand untouched until a load from the core
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                sel_q[i] <= SEL_RST;
                attr_q[i] <= ATTR_REAL;
                unusable_q[i] <= 1'b0;
            end else if (hit) begin
                sel_q[i] <= segIf.loadSel;
                attr_q[i] <= segIf.realMode ? ATTR_REAL : segIf.loadAttr;
                unusable_q[i] <= !segIf.realMode && isNullSel(segIf.loadSel);
            end
        end
    end

    // a null selector taken in protected mode leaves the register unusable once real
    assign segIf.rdSel = sel_q[segIf.rdIdx];
    assign segIf.rdAttr = attr_q[segIf.rdIdx];
    assign segIf.rdUsable = !(unusable_q[segIf.rdIdx] && segIf.realMode);

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    AST_SEG_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        !segIf.loadEn |=> (sel_q[0] == $past(sel_q[0])) && (attr_q[0] == $past(attr_q[0])))
        else $error("segment register changed without a load");
    AST_NULL_UNUSABLE: assert property (@(posedge clk) disable iff (!rst_b)
        (segIf.loadEn && !segIf.realMode && isNullSel(segIf.loadSel) && segIf.loadIdx == 3'h1)
        |=> unusable_q[1] && (!segIf.realMode || segIf.rdIdx != 3'h1 || !segIf.rdUsable))
        else $error("null selector usable in real mode");
endmodule
`default_nettype wire

// File: comc_seg_if.sv
// interface between the mode controller and its segment register bank
`timescale 1ns/100ps
`default_nettype none
interface comc_seg_if;
    import comc_pkg::*;
    logic loadEn;
    logic [SEG_IDX_W-1:0] loadIdx;
    logic [SEL_W-1:0] loadSel;
    logic [ATTR_W-1:0] loadAttr;
    logic realMode;
    logic [SEG_IDX_W-1:0] rdIdx;
    logic [SEL_W-1:0] rdSel;
    logic [ATTR_W-1:0] rdAttr;
    logic rdUsable;

    modport ctrl (output loadEn, loadIdx, loadSel, loadAttr, realMode, rdIdx,
                  input rdSel, rdAttr, rdUsable);
    modport bank (input loadEn, loadIdx, loadSel, loadAttr, realMode, rdIdx,
                  output rdSel, rdAttr, rdUsable);
endinterface
`default_nettype wire

// File: comc_sw_model.sv
// partner model: system software driving the register port
`timescale 1ns/100ps
`default_nettype none
module comc_sw_model
    import comc_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output logic [ADDR_W-1:0] regAddr,
    output logic [DATA_W-1:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [DATA_W-1:0] regRdData
);
    initial begin
        regAddr = 8'h00;
        regWrData = 32'h0000_0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    // one write, then a spare edge so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
        regAddr <= ~a;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        #1 d = regRdData;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// File: cpu_operating_mode_control_bench.sv
// self-checking testbench of the operating mode controller
`timescale 1ns/100ps
`default_nettype none
module cpu_operating_mode_control_bench;
    import comc_pkg::*;
    logic clk, rst_b, farBranch, fbLong, segLoad, upWr, protOn, pagingOn, long_mode_active_flag, upValid, serPulse, flushQ;
    logic regWrEn, regRdEn;
    logic [7:0] regAddr, segAttr;
    logic [2:0] segIdx;
    logic [15:0] fbSel, segSel;
    logic [31:0] regWrData, regRdData, fbBase, csBase;
    logic [1:0] cpuMode, curPriv;
    int nMismatch = 0;
    int nChecks = 0;
    comc_sw_model comc_sw_model_inst (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));
    comc_mode_ctrl comc_mode_ctrl_inst (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .farBranch(farBranch),
        .farBranchSel(fbSel), .farBranchBase(fbBase), .farBranchLong(fbLong), .segLoad(segLoad),
        .segLoadIdx(segIdx), .segLoadSel(segSel), .segLoadAttr(segAttr), .upperRegWrite(upWr),
        .cpuMode(cpuMode), .curPriv(curPriv), .protOn(protOn), .pagingOn(pagingOn),
        .longModeActive(long_mode_active_flag), .upperRegsValid(upValid), .serializePulse(serPulse),
        .flushQueue(flushQ), .csBase(csBase));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    //--------------------------------------------------------------------------
    // shared tasks
    //--------------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        comc_sw_model_inst.rd(a, d);
        chk(d, exp);
    endtask
    // far branch pulse; the pulses answer one cycle later and only then
    task automatic branch(input logic [15:0] s, input logic [31:0] b, input logic l, input logic ser, fl);
        farBranch <= 1'b1;
        fbSel <= s;
        fbBase <= b;
        fbLong <= l;
        @(posedge clk);
        farBranch <= 1'b0;
        fbBase <= ~b;
        #1 chk({30'h0, serPulse, flushQ}, {30'h0, ser, fl});
        @(posedge clk);
    endtask
    task automatic pulseCore(input logic sl, input logic [2:0] i, input logic [15:0] s, input logic [7:0] a);
        segLoad <= sl;
        upWr <= ~sl;
        segIdx <= i;
        segSel <= s;
        segAttr <= a;
        @(posedge clk);
        segLoad <= 1'b0;
        upWr <= 1'b0;
        segSel <= ~s;
        @(posedge clk);
    endtask
    //--------------------------------------------------------------------------
    // scenarios
    //--------------------------------------------------------------------------
    task automatic testEnterProt();
        chk({cpuMode, protOn, long_mode_active_flag, csBase[3:0]}, 8'h00);
        pulseCore(1'b1, 3'h0, 16'h1234, 8'h00);
        comc_sw_model_inst.wr(OFF_MCTL, 32'h8000_0000);
        chk(pagingOn, 1'b0);
        comc_sw_model_inst.wr(OFF_GTBASE, 32'h0001_0000);
        comc_sw_model_inst.wr(OFF_MCTL, 32'h0000_0001);
        chk({cpuMode, curPriv, protOn}, {MODE_PROT, 2'h0, 1'b1});
        branch(16'h0008, 32'h0040_0000, 1'b0, 1'b1, 1'b0);
        chk(csBase, 32'h0040_0000);
        rdChk(OFF_STATUS, 32'h0000_0001);
        comc_sw_model_inst.wr(OFF_LTSEL, 32'h0000_0028);
        comc_sw_model_inst.wr(OFF_TSSEL, 32'h0000_0030);
        comc_sw_model_inst.wr(OFF_ITBASE, 32'h0002_0000);
        rdChk(OFF_TSSEL, 32'h0000_0030);
        rdChk(OFF_SEG0, 32'h0193_1234);
    endtask
    task automatic testLong();
        comc_sw_model_inst.wr(OFF_EFR, 32'h0000_0100);
        comc_sw_model_inst.wr(OFF_MCTL, 32'h8000_0001);
        rdChk(OFF_EFR, 32'h0000_0500);
        branch(16'h0010, 32'h0000_0000, 1'b1, 1'b0, 1'b0);
        pulseCore(1'b0, 3'h0, 16'h0000, 8'h00);
        branch(16'h0018, 32'h0000_0000, 1'b0, 1'b0, 1'b0);
        chk(cpuMode, MODE_COMPAT);
        branch(16'h0010, 32'h0000_0000, 1'b1, 1'b0, 1'b0);
        chk({cpuMode, upValid}, {MODE_LONG64, 1'b1});
        branch(16'h0018, 32'h0000_0000, 1'b0, 1'b0, 1'b0);
        chk({cpuMode, upValid}, {MODE_COMPAT, 1'b1});
        comc_sw_model_inst.wr(OFF_MCTL, 32'h0000_0001);
        chk({long_mode_active_flag, upValid}, 2'b00);
        comc_sw_model_inst.wr(OFF_PGBASE, 32'h0000_2000);
        comc_sw_model_inst.wr(OFF_EFR, 32'h0000_0000);
        comc_sw_model_inst.wr(OFF_MCTL, 32'h8000_0001);
        chk({pagingOn, long_mode_active_flag}, 2'b10);
        branch(16'h0008, 32'h0000_0000, 1'b0, 1'b0, 1'b0);
        chk(cpuMode, MODE_PROT);
    endtask
    task automatic testBackToReal();
        comc_sw_model_inst.wr(OFF_MCTL, 32'h0000_0001);
        comc_sw_model_inst.wr(OFF_PGBASE, 32'h0000_0000);
        branch(16'h0020, 32'h0000_0000, 1'b0, 1'b0, 1'b0);
        pulseCore(1'b1, 3'h1, 16'h0000, 8'h93);
        pulseCore(1'b1, 3'h2, 16'h0010, 8'h93);
        comc_sw_model_inst.wr(OFF_ITBASE, 32'h0000_0400);
        comc_sw_model_inst.wr(OFF_MCTL, 32'h0000_0000);
        chk({cpuMode, protOn}, {MODE_REAL, 1'b0});
        branch(16'h2000, 32'h0000_DEAD, 1'b0, 1'b1, 1'b1);
        chk(csBase, 32'h0002_0000);
        rdChk(OFF_SEG0 + 8'h04, 32'h0093_0000);
        rdChk(OFF_SEG0, 32'h0193_1234);
        rdChk(OFF_SEG0 + 8'h08, 32'h0193_0010);
    endtask
    initial begin
        {rst_b, farBranch, fbLong, segLoad, upWr, segIdx, segAttr} = '0;
        {fbSel, segSel, fbBase} = '0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        testEnterProt();
        testLong();
        testBackToReal();
        end_of_test();
    end
    // watchdog: the whole run takes about eighty cycles
    initial begin
        repeat (3000) @(posedge clk);
        nMismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
